// ### verilog/lpi_pkg.sv
// Package with register map, field layout and types of the interrupt bank.
// How it works
// - Status bit 7 shows a pending near event.
// - Bits 6:5 pick 1, 2, 4 or 8 consecutive near events before the pin.
// - Bits 2:1 pick 1, 2, 4 or 8 consecutive light events before the pin.
// - Status bit 3 shows a pending light event.
// - Bit 0 set means pin needs both events; clear means either one.
// - Bit 4 is set when the supply was interrupted.
// - A brownout sets only its status bit, never the pin.
// - Writing 0 to bit 4 clears the brownout alarm.
// - Near low limit at 0x05 resets 0x00, high limit at 0x06 resets 0xff.
// - Light 12-bit limits packed over 0x07, 0x08 and 0x09.
// - Shared light limit byte resets 0x0f, high lower byte resets 0xff.
// - Register 0x0a holds the latest near result.
// - Light result low byte at 0x0c, upper nibble right-justified at 0x0b.
// - Bits 7:1 of 0x0d hold the ambient infrared level.
// - Bit 0 of 0x0d shows the washout condition.
// - Writing 0x38 to 0x0e starts a software reset.
// - Light flag sets when the result lies outside the limits.
// - Near flag sets above high limit, clears below low limit or on write 0.
// - Pin goes low only after the chosen count; each source counts alone.
`default_nettype none
package lpi_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] LPI_ADDR_INT_CFG = 8'h04;
	localparam logic [7:0] LPI_ADDR_NEAR_LO = 8'h05;
	localparam logic [7:0] LPI_ADDR_NEAR_HI = 8'h06;
	localparam logic [7:0] LPI_ADDR_LIGHT_LO_UP = 8'h07;
	localparam logic [7:0] LPI_ADDR_LIGHT_SHARED = 8'h08;
	localparam logic [7:0] LPI_ADDR_LIGHT_HI_LOW = 8'h09;
	localparam logic [7:0] LPI_ADDR_NEAR_RESULT = 8'h0a;
	localparam logic [7:0] LPI_ADDR_LIGHT_RES_HI = 8'h0b;
	localparam logic [7:0] LPI_ADDR_LIGHT_RES_LO = 8'h0c;
	localparam logic [7:0] LPI_ADDR_AMBIENT_IR = 8'h0d;
	localparam logic [7:0] LPI_ADDR_SOFT_RESET = 8'h0e;

	// ************************************************************
	// Field positions and values
	// ************************************************************
	localparam int LPI_BIT_NEAR_FLAG = 7;
	localparam int LPI_BIT_NEAR_PRST_HI = 6;
	localparam int LPI_BIT_NEAR_PRST_LO = 5;
	localparam int LPI_BIT_BROWNOUT = 4;
	localparam int LPI_BIT_LIGHT_FLAG = 3;
	localparam int LPI_BIT_LIGHT_PRST_HI = 2;
	localparam int LPI_BIT_LIGHT_PRST_LO = 1;
	localparam int LPI_BIT_AND_MODE = 0;
	localparam logic [7:0] LPI_SOFT_RESET_CODE = 8'h38;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] LPI_RST_INT_CFG = 8'h10;
	localparam logic [7:0] LPI_RST_NEAR_LO = 8'h00;
	localparam logic [7:0] LPI_RST_NEAR_HI = 8'hff;
	localparam logic [7:0] LPI_RST_LIGHT_LO_UP = 8'h00;
	localparam logic [7:0] LPI_RST_LIGHT_SHARED = 8'h0f;
	localparam logic [7:0] LPI_RST_LIGHT_HI_LOW = 8'hff;
	localparam logic [7:0] LPI_RST_SOFT_RESET = 8'h00;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lpi_bus_req_t;

	typedef struct packed {
		logic near_valid;
		logic [7:0] near_value;
		logic [6:0] ambient_ir;
		logic washout;
		logic light_valid;
		logic [11:0] light_value;
	} lpi_meas_t;

endpackage
`default_nettype wire

// ### verilog/lpi_regs.sv
// Interrupt configuration, limit and result registers of the sensor.
`timescale 1ns/1ns
`default_nettype none
module lpi_regs
	import lpi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire lpi_bus_req_t i_req,
	input wire lpi_meas_t i_meas,
	input wire logic i_brownout,
	output logic [7:0] o_rdata,
	output logic o_int_n
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic near_flag_reg;
	logic light_flag_reg;
	logic brownout_reg;
	logic [1:0] near_prst_reg;
	logic [1:0] light_prst_reg;
	logic and_mode_reg;
	logic [7:0] near_low_limit_reg;
	logic [7:0] near_high_limit_reg;
	logic [7:0] light_low_limit_upper_reg;
	logic [7:0] light_limits_shared_reg;
	logic [7:0] light_high_limit_lower_reg;
	logic [7:0] near_result_reg;
	logic [11:0] light_result_reg;
	logic [7:0] ambient_infrared_status_reg;
	logic [3:0] near_count_reg;
	logic [3:0] light_count_reg;
	logic near_pin_reg;
	logic light_pin_reg;
	logic [7:0] rdata_reg;
	logic soft_reset;
	logic wr_cfg;
	logic [11:0] light_low;
	logic [11:0] light_high;
	logic light_out;
	logic near_above;
	logic near_below;
	logic near_next;
	logic [3:0] near_need;
	logic [3:0] light_need;
	logic [7:0] int_cfg_view;
	logic near_clr;
	logic light_clr;

	assign wr_cfg = i_req.wr && (i_req.addr == LPI_ADDR_INT_CFG);
	// A host clear releases the pin at once instead of one cycle later.
	assign near_clr = wr_cfg && !i_req.wdata[LPI_BIT_NEAR_FLAG];
	assign light_clr = wr_cfg && !i_req.wdata[LPI_BIT_LIGHT_FLAG];
	// The reset command acts in the same cycle so the register never holds
	// the code; it therefore always reads back as zero.
	assign soft_reset = i_req.wr && (i_req.addr == LPI_ADDR_SOFT_RESET)
		&& (i_req.wdata == LPI_SOFT_RESET_CODE);

	assign light_low = {light_low_limit_upper_reg,
		light_limits_shared_reg[7:4]};
	assign light_high = {light_limits_shared_reg[3:0],
		light_high_limit_lower_reg};

	// ************************************************************
	// Comparators and persistence
	// ************************************************************
	assign light_out = (i_meas.light_value < light_low)
		|| (i_meas.light_value > light_high);
	assign near_above = i_meas.near_value > near_high_limit_reg;
	assign near_below = i_meas.near_value < near_low_limit_reg;
	assign near_next = near_above || (near_flag_reg && !near_below);

	always_comb
	begin
		case (near_prst_reg)
			2'h0: near_need = 4'h1;
			2'h1: near_need = 4'h2;
			2'h2: near_need = 4'h4;
			default: near_need = 4'h8;
		endcase
		case (light_prst_reg)
			2'h0: light_need = 4'h1;
			2'h1: light_need = 4'h2;
			2'h2: light_need = 4'h4;
			default: light_need = 4'h8;
		endcase
	end

	// ************************************************************
	// Interrupt configuration and status
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			near_prst_reg <= LPI_RST_INT_CFG[6:5];
			light_prst_reg <= LPI_RST_INT_CFG[2:1];
			and_mode_reg <= LPI_RST_INT_CFG[0];
		end
		else if (soft_reset)
		begin
			near_prst_reg <= LPI_RST_INT_CFG[6:5];
			light_prst_reg <= LPI_RST_INT_CFG[2:1];
			and_mode_reg <= LPI_RST_INT_CFG[0];
		end
		else if (wr_cfg)
		begin
			near_prst_reg <=
				i_req.wdata[LPI_BIT_NEAR_PRST_HI:LPI_BIT_NEAR_PRST_LO];
			light_prst_reg <=
				i_req.wdata[LPI_BIT_LIGHT_PRST_HI:LPI_BIT_LIGHT_PRST_LO];
			and_mode_reg <= i_req.wdata[LPI_BIT_AND_MODE];
		end
	end

	// Hardware setting wins over a clearing write in the same cycle.
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			brownout_reg <= LPI_RST_INT_CFG[4];
			near_flag_reg <= 1'b0;
			light_flag_reg <= 1'b0;
		end
		else
		begin
			if (i_brownout)
				brownout_reg <= 1'b1;
			else if (wr_cfg && !i_req.wdata[LPI_BIT_BROWNOUT])
				brownout_reg <= 1'b0;
			if (soft_reset)
				near_flag_reg <= 1'b0;
			else if (i_meas.near_valid && near_above)
				near_flag_reg <= 1'b1;
			else if (i_meas.near_valid && near_below)
				near_flag_reg <= 1'b0;
			else if (wr_cfg && !i_req.wdata[LPI_BIT_NEAR_FLAG])
				near_flag_reg <= 1'b0;
			if (soft_reset)
				light_flag_reg <= 1'b0;
			else if (i_meas.light_valid && light_out)
				light_flag_reg <= 1'b1;
			else if (wr_cfg && !i_req.wdata[LPI_BIT_LIGHT_FLAG])
				light_flag_reg <= 1'b0;
		end
	end

	// Counters saturate at the needed count so a long run keeps the pin low.
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			near_count_reg <= 4'h0;
			light_count_reg <= 4'h0;
			near_pin_reg <= 1'b0;
			light_pin_reg <= 1'b0;
		end
		else if (soft_reset)
		begin
			near_count_reg <= 4'h0;
			light_count_reg <= 4'h0;
			near_pin_reg <= 1'b0;
			light_pin_reg <= 1'b0;
		end
		else
		begin
			if (i_meas.near_valid)
			begin
				if (!near_next)
				begin
					near_count_reg <= 4'h0;
					near_pin_reg <= 1'b0;
				end
				else if (near_count_reg + 4'h1 >= near_need)
				begin
					near_count_reg <= near_need;
					near_pin_reg <= 1'b1;
				end
				else
					near_count_reg <= near_count_reg + 4'h1;
			end
			else if (!near_flag_reg || near_clr)
				near_pin_reg <= 1'b0;
			if (i_meas.light_valid)
			begin
				if (!light_out)
				begin
					light_count_reg <= 4'h0;
					light_pin_reg <= 1'b0;
				end
				else if (light_count_reg + 4'h1 >= light_need)
				begin
					light_count_reg <= light_need;
					light_pin_reg <= 1'b1;
				end
				else
					light_count_reg <= light_count_reg + 4'h1;
			end
			else if (!light_flag_reg || light_clr)
				light_pin_reg <= 1'b0;
		end
	end

	// The brownout alarm takes no part in the pin.
	assign o_int_n = and_mode_reg ? !(near_pin_reg && light_pin_reg)
		: !(near_pin_reg || light_pin_reg);

	// ************************************************************
	// Limit registers
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			near_low_limit_reg <= LPI_RST_NEAR_LO;
			near_high_limit_reg <= LPI_RST_NEAR_HI;
			light_low_limit_upper_reg <= LPI_RST_LIGHT_LO_UP;
			light_limits_shared_reg <= LPI_RST_LIGHT_SHARED;
			light_high_limit_lower_reg <= LPI_RST_LIGHT_HI_LOW;
		end
		else if (soft_reset)
		begin
			near_low_limit_reg <= LPI_RST_NEAR_LO;
			near_high_limit_reg <= LPI_RST_NEAR_HI;
			light_low_limit_upper_reg <= LPI_RST_LIGHT_LO_UP;
			light_limits_shared_reg <= LPI_RST_LIGHT_SHARED;
			light_high_limit_lower_reg <= LPI_RST_LIGHT_HI_LOW;
		end
		else if (i_req.wr)
		begin
			if (i_req.addr == LPI_ADDR_NEAR_LO)
				near_low_limit_reg <= i_req.wdata;
			else if (i_req.addr == LPI_ADDR_NEAR_HI)
				near_high_limit_reg <= i_req.wdata;
			else if (i_req.addr == LPI_ADDR_LIGHT_LO_UP)
				light_low_limit_upper_reg <= i_req.wdata;
			else if (i_req.addr == LPI_ADDR_LIGHT_SHARED)
				light_limits_shared_reg <= i_req.wdata;
			else if (i_req.addr == LPI_ADDR_LIGHT_HI_LOW)
				light_high_limit_lower_reg <= i_req.wdata;
		end
	end

	// ************************************************************
	// Result registers
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			near_result_reg <= 8'h00;
			ambient_infrared_status_reg <= 8'h00;
			light_result_reg <= 12'h000;
		end
		else
		begin
			if (i_meas.near_valid)
			begin
				near_result_reg <= i_meas.near_value;
				ambient_infrared_status_reg <=
					{i_meas.ambient_ir, i_meas.washout};
			end
			if (i_meas.light_valid)
				light_result_reg <= i_meas.light_value;
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	assign int_cfg_view = {near_flag_reg, near_prst_reg, brownout_reg,
		light_flag_reg, light_prst_reg, and_mode_reg};

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rdata_reg <= 8'h00;
		else if (i_req.rd)
		begin
			if (i_req.addr == LPI_ADDR_INT_CFG)
				rdata_reg <= int_cfg_view;
			else if (i_req.addr == LPI_ADDR_NEAR_LO)
				rdata_reg <= near_low_limit_reg;
			else if (i_req.addr == LPI_ADDR_NEAR_HI)
				rdata_reg <= near_high_limit_reg;
			else if (i_req.addr == LPI_ADDR_LIGHT_LO_UP)
				rdata_reg <= light_low_limit_upper_reg;
			else if (i_req.addr == LPI_ADDR_LIGHT_SHARED)
				rdata_reg <= light_limits_shared_reg;
			else if (i_req.addr == LPI_ADDR_LIGHT_HI_LOW)
				rdata_reg <= light_high_limit_lower_reg;
			else if (i_req.addr == LPI_ADDR_NEAR_RESULT)
				rdata_reg <= near_result_reg;
			else if (i_req.addr == LPI_ADDR_LIGHT_RES_HI)
				rdata_reg <= {4'h0, light_result_reg[11:8]};
			else if (i_req.addr == LPI_ADDR_LIGHT_RES_LO)
				rdata_reg <= light_result_reg[7:0];
			else if (i_req.addr == LPI_ADDR_AMBIENT_IR)
				rdata_reg <= ambient_infrared_status_reg;
			else if (i_req.addr == LPI_ADDR_SOFT_RESET)
				rdata_reg <= LPI_RST_SOFT_RESET;
			else
				rdata_reg <= 8'h00;
		end
	end

	assign o_rdata = rdata_reg;

endmodule
`default_nettype wire

// ### verification/lpi_regs_sva.sv
// Port checker of the interrupt register bank.
`timescale 1ns/1ns
`default_nettype none
module lpi_regs_sva
	import lpi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire lpi_bus_req_t i_req,
	input wire lpi_meas_t i_meas,
	input wire logic i_brownout,
	input wire logic [7:0] o_rdata,
	input wire logic o_int_n
);
	// ****
	// Last measurements, valid once seen
	// ****
	logic [7:0] near_reg;
	logic [7:0] amb_reg;
	logic [11:0] light_reg;
	logic [1:0] seen_reg;
	wire logic [7:0] ra = i_req.addr;
	wire logic no_meas = !i_meas.near_valid && !i_meas.light_valid;
	wire logic rq = i_req.rd && no_meas;
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			seen_reg <= 2'h0;
		else
			seen_reg <= seen_reg | {i_meas.light_valid, i_meas.near_valid};
	end
	// Copies are only compared once a result has been seen, so they need no reset.
	always_ff @(posedge i_clk)
	begin
		if (i_meas.near_valid)
		begin
			near_reg <= i_meas.near_value;
			amb_reg <= {i_meas.ambient_ir, i_meas.washout};
		end
		if (i_meas.light_valid)
			light_reg <= i_meas.light_value;
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_near_result: assert property (
		rq && ra == 8'h0a && seen_reg[0] |=> o_rdata == near_reg)
		else $error("near result read wrong");
	a_ambient_ir: assert property (
		rq && ra == 8'h0d && seen_reg[0] |=> o_rdata == amb_reg)
		else $error("ambient status read wrong");
	a_light_low: assert property (
		rq && ra == 8'h0c && seen_reg[1] |=> o_rdata == light_reg[7:0])
		else $error("light low byte wrong");
	a_light_high: assert property (
		rq && ra == 8'h0b && seen_reg[1] |=>
		o_rdata == {4'h0, light_reg[11:8]})
		else $error("light high byte wrong");
	a_unmapped_zero: assert property (
		i_req.rd && (ra > 8'h0d || ra < 8'h04) |=> o_rdata == 8'h00)
		else $error("command or unmapped read not zero");
	a_brownout_sets: assert property (
		i_brownout ##1 (i_req.rd && ra == 8'h04 && !i_req.wr) |=> o_rdata[4])
		else $error("brownout alarm not set");
	a_brownout_pin: assert property (
		i_brownout && o_int_n && no_meas && !i_req.wr |=> o_int_n)
		else $error("brownout moved the pin");
	a_flags_clear: assert property (
		i_req.wr && ra == 8'h04 && i_req.wdata == 8'h00 && no_meas |=> o_int_n)
		else $error("pin low after flags cleared");
	c_pin_low: cover property (!o_int_n);
	c_near_read: cover property (rq && ra == 8'h0a && seen_reg[0]);
	c_brownout: cover property (i_brownout ##1 i_req.rd);
endmodule
bind lpi_regs lpi_regs_sva lpi_regs_sva_inst (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_req(i_req), .i_meas(i_meas),
	.i_brownout(i_brownout), .o_rdata(o_rdata), .o_int_n(o_int_n));
`default_nettype wire

// ### verification/lpi_host.sv
// Host model issuing register reads and writes.
`timescale 1ns/1ns
`default_nettype none
module lpi_host
	import lpi_pkg::*;
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output var lpi_bus_req_t o_req
);
	// ****
	// Access tasks
	// ****
	initial o_req = '0;
	// Idle address and data are inverted after a write, the address alone after a read, so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clk);
		o_req.rd = 1'b0;
		o_req.addr = ~a;
		@(negedge i_clk);
		v = i_rdata;
	endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the interrupt register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench
	import lpi_pkg::*;
;
	// ****
	// Signals and tasks
	// ****
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_brownout = 1'b0;
	lpi_meas_t meas_s = '0;
	lpi_bus_req_t req_s;
	logic [7:0] rdata;
	logic int_n;
	logic [7:0] d;
	logic [7:0] cfg;
	logic [11:0] hi [2] = '{12'h090, 12'h900};
	logic [11:0] lo [2] = '{12'h005, 12'h400};
	int error_cnt = 0;
	int check_count = 0;
	always #25 i_clk = ~i_clk;
	lpi_host lpi_host_inst (.i_clk(i_clk), .i_rdata(rdata), .o_req(req_s));
	lpi_regs lpi_regs_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_req(req_s), .i_meas(meas_s), .i_brownout(i_brownout),
		.o_rdata(rdata), .o_int_n(int_n));
	task automatic fail(input string m);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		lpi_host_inst.rd(a, d);
		check_count++;
		if (d !== e)
			fail($sformatf("reg %h read %h want %h", a, d, e));
	endtask
	task automatic chk_pin(input logic e);
		check_count++;
		if (int_n !== e)
			fail($sformatf("pin %b want %b", int_n, e));
	endtask
	task automatic meas(input int s, input logic [11:0] v);
		@(negedge i_clk);
		meas_s.near_valid = (s == 0);
		meas_s.light_valid = (s == 1);
		meas_s.near_value = v[7:0];
		meas_s.light_value = v;
		@(negedge i_clk);
		meas_s.near_valid = 1'b0;
		meas_s.light_valid = 1'b0;
	endtask
	task automatic check_defaults();
		logic [7:0] rv [5] = '{8'h00, 8'hff, 8'h00, 8'h0f, 8'hff};
		for (int i = 0; i < 5; i++)
			rd_chk(8'h05 + 8'(i), rv[i]);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial
	begin
		meas_s.ambient_ir = 7'h55;
		meas_s.washout = 1'b1;
		repeat (20) @(negedge i_clk);
		i_reset_n = 1'b1;
		check_defaults();
		rd_chk(8'h04, 8'h10);
		lpi_host_inst.wr(8'h04, 8'h00);
		rd_chk(8'h04, 8'h00);
		i_brownout = 1'b1;
		rd_chk(8'h04, 8'h10);
		chk_pin(1'b1);
		i_brownout = 1'b0;
		lpi_host_inst.wr(8'h05, 8'h10);
		lpi_host_inst.wr(8'h06, 8'h80);
		lpi_host_inst.wr(8'h07, 8'h10);
		lpi_host_inst.wr(8'h08, 8'h08);
		lpi_host_inst.wr(8'h09, 8'h00);
		rd_chk(8'h08, 8'h08);
		// Every persistence code of both sources, ended by a failing sample.
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 4; c++)
			begin
				cfg = (s == 0) ? 8'(c << 5) : 8'(c << 1);
				lpi_host_inst.wr(8'h04, cfg);
				repeat ((1 << c) - 1)
				begin
					meas(s, hi[s]);
					chk_pin(1'b1);
				end
				meas(s, hi[s]);
				chk_pin(1'b0);
				rd_chk(8'h04, cfg | ((s == 0) ? 8'h80 : 8'h08));
				meas(s, lo[s]);
				chk_pin(1'b1);
			end
		// A failing sample between two events must restart the count.
		lpi_host_inst.wr(8'h04, 8'h20);
		meas(0, 12'h090);
		meas(0, 12'h005);
		meas(0, 12'h090);
		chk_pin(1'b1);
		meas(0, 12'h005);
		lpi_host_inst.wr(8'h04, 8'h01);
		meas(0, 12'h090);
		chk_pin(1'b1);
		meas(1, 12'h050);
		chk_pin(1'b0);
		lpi_host_inst.wr(8'h04, 8'h00);
		chk_pin(1'b1);
		meas(1, 12'habc);
		rd_chk(8'h0b, 8'h0a);
		rd_chk(8'h0c, 8'hbc);
		rd_chk(8'h0d, 8'hab);
		rd_chk(8'h0a, 8'h90);
		lpi_host_inst.wr(8'h0e, 8'h38);
		check_defaults();
		rd_chk(8'h04, 8'h00);
		chk_pin(1'b1);
		rd_chk(8'h0e, 8'h00);
		stop_test();
	end
	initial
	begin
		#400000;
		fail("run did not finish");
		stop_test();
	end
endmodule
`default_nettype wire
